// ===== fmn_consts.svh
// Constants of the floating-point multiply and negate unit.
// Assumes inclusion by bare name from the unit and its test files.
`ifndef FMN_CONSTS_SVH
`define FMN_CONSTS_SVH
`define FMN_PRIM_DBL 6'h3F
`define FMN_PRIM_SGL 6'h3B
`define FMN_XO_MUL 5'h19
`define FMN_XO_NMADD 5'h1F
`define FMN_XO_NMSUB 5'h1E
`define FMN_XO_NABS 10'h088
`define FMN_XO_NEG 10'h028
`define FMN_RND_NEAR 2'h0
`define FMN_RND_ZERO 2'h1
`define FMN_RND_PINF 2'h2
`define FMN_RND_MINF 2'h3
`define FMN_CLS_QNAN 5'h11
`define FMN_CLS_NINF 5'h09
`define FMN_CLS_NNORM 5'h08
`define FMN_CLS_NDEN 5'h18
`define FMN_CLS_NZERO 5'h12
`define FMN_CLS_PZERO 5'h02
`define FMN_CLS_PDEN 5'h14
`define FMN_CLS_PNORM 5'h04
`define FMN_CLS_PINF 5'h05
`define FMN_DEF_QNAN 64'h7FF8_0000_0000_0000
`define FMN_QUIET_MASK 64'h0008_0000_0000_0000
`define FMN_SGL_KEEP 64'hFFFF_FFFF_E000_0000
`define FMN_ADDR_CTRL 4'h0
`define FMN_ADDR_STAT 4'h4
`define FMN_ADDR_MASK 4'h8
`define FMN_CTRL_RST 6'h00
`define FMN_CTRL_INV_EN 2
`define FMN_CTRL_OE 3
`define FMN_CTRL_UE 4
`define FMN_CTRL_XE 5
`define FMN_EV_INV 0
`define FMN_EV_OVF 1
`define FMN_EV_UNF 2
`define FMN_EV_INX 3
`define FMN_BIAS 1023
`define FMN_PREC_DBL 53
`define FMN_PREC_SGL 24
`define FMN_EMIN_DBL -1022
`define FMN_EMIN_SGL -126
`define FMN_EMAX_DBL 1023
`define FMN_EMAX_SGL 127
`define FMN_XB_OFS 2154
`define FMN_YB_OFS 1132
`endif

// ===== fmn_pkg.sv
// Types of the floating-point multiply and negate unit.
// Assumes the constants header is compiled alongside.
package fmn_pkg;
   typedef enum logic [2:0] {OP_NONE, OP_MUL, OP_NMADD, OP_NMSUB, OP_NABS, OP_NEG} fmn_op_t;
   typedef struct packed {
      logic valid;
      logic [31:0] instr;
      logic [63:0] opa;
      logic [63:0] opb;
      logic [63:0] opc;
   } fmn_issue_t;
   typedef struct packed {
      logic valid;
      logic we;
      logic illegal;
      logic [4:0] dst;
      logic [63:0] data;
   } fmn_res_t;
   typedef struct packed {
      logic we;
      logic result_class_field_we;
      logic [4:0] result_class_field;
      logic fr;
      logic fi;
      logic exception_summary;
      logic enabled_exception_summary;
      logic invalid_summary;
      logic overflow_flag;
      logic ux;
      logic xx;
      logic vxsnan;
      logic vxisi;
      logic vximz;
   } fmn_upd_t;
   typedef struct packed {
      logic we;
      logic [3:0] val;
   } fmn_cr_t;
   typedef struct packed {
      logic [63:0] data;
      logic [4:0] result_class_field;
      logic nowrite;
      logic fr;
      logic fi;
      logic overflow_flag;
      logic ux;
      logic xx;
      logic vxsnan;
      logic vxisi;
      logic vximz;
   } fmn_arith_t;
   typedef struct packed {
      fmn_res_t res;
      fmn_upd_t upd;
      fmn_cr_t cr;
      logic [5:0] ctrl;
      logic [3:0] stat;
      logic [3:0] mask;
      logic [31:0] rdata;
      logic irq;
   } fmn_state_t;
endpackage

// ===== fmn_unit.sv
// Floating-point multiply, negative fused multiply-add/subtract and sign unit.
// Assumes the core issues one instruction per valid pulse with operands read,
// and applies the status updates and condition field writes it is handed.
//
// Overview of operation
// - Double multiply: A times C, double rounding
// - Single multiply: same product, single rounding
// - Normalize significand before rounding
// - Add exponents, multiply significands
// - Set class field unless enabled invalid
// - Record bit copies summaries into condition field
// - Negative absolute forces sign bit one
// - Negate inverts sign bit only
// - Sign ops ignore NaN, leave status alone
// - Double neg multiply-add: negate rounded A*C+B
// - Single neg multiply-add, opcodes 59/31
// - Double neg multiply-subtract: negate rounded A*C-B
// - Round first, then invert sign
// - Propagated quiet NaN keeps its sign
// - Generated default NaN has positive sign
// - Quieted signaling NaN keeps its sign
// - Fused ops update all listed status bits
`timescale 1ns/1ns
`default_nettype none
`include "fmn_consts.svh"
module fmn_unit
   import fmn_pkg::*;
(
   input wire logic i_ref_clk,
   input wire logic i_sys_rst,
   input wire fmn_issue_t i_issue,
   input wire logic [3:0] i_fp_sum,
   input wire logic [3:0] i_reg_addr,
   input wire logic [31:0] i_reg_wdata,
   input wire logic i_reg_we,
   input wire logic i_reg_re,
   output logic [31:0] o_reg_rdata,
   output fmn_res_t o_res,
   output fmn_upd_t o_upd,
   output fmn_cr_t o_cond_field_one,
   output logic o_irq
);
   fmn_state_t q;
   fmn_state_t nx;
   fmn_arith_t ar;
   fmn_op_t op;

   function automatic logic is_nan(input logic [63:0] v);
      return (v[62:52] == 11'h7FF) && (v[51:0] != 52'h0);
   endfunction

   function automatic logic is_inf(input logic [63:0] v);
      return (v[62:52] == 11'h7FF) && (v[51:0] == 52'h0);
   endfunction

   function automatic logic is_snan(input logic [63:0] v);
      return is_nan(v) && !v[51];
   endfunction

   function automatic logic is_zero(input logic [63:0] v);
      return v[62:0] == 63'h0;
   endfunction

   function automatic logic [6:0] lzc(input logic [110:0] v);
      logic [6:0] c;
      c = 7'd111;
      for (int i = 0; i < 111; i++)
      begin
         if (v[i])
            c = 7'(110 - i);
      end
      return c;
   endfunction

   function automatic logic [4:0] fp_class(input logic [63:0] v, input logic den);
      if (is_nan(v))
         return `FMN_CLS_QNAN;
      if (is_inf(v))
         return v[63] ? `FMN_CLS_NINF : `FMN_CLS_PINF;
      if (is_zero(v))
         return v[63] ? `FMN_CLS_NZERO : `FMN_CLS_PZERO;
      if (den)
         return v[63] ? `FMN_CLS_NDEN : `FMN_CLS_PDEN;
      return v[63] ? `FMN_CLS_NNORM : `FMN_CLS_PNORM;
   endfunction

   // One-pass fused datapath; a plain multiply is a fused op with a zero addend
   function automatic fmn_arith_t fma_core(input logic [63:0] a, input logic [63:0] b,
      input logic [63:0] c, input logic sgl, input logic sub, input logic mul,
      input logic neg, input logic [1:0] rounding_mode_field, input logic invalid_enable_bit);
      fmn_arith_t r;
      logic [63:0] bb;
      logic [10:0] ea, eb, ec;
      logic [52:0] ma, mb, mc, fm;
      logic [105:0] pm;
      logic [109:0] x, y, big, sml, sh;
      logic [110:0] n;
      logic [110:0] mfull;
      logic [53:0] m;
      logic [6:0] lz;
      logic ps, bs, rs, anynan, pinf, g, st, inc, tiny, den, toinf;
      int xb, yb, bse, d, e, emin, emax, p, s;
      r = '0;
      bb = mul ? {a[63] ^ c[63], 63'h0} : b;
      ps = a[63] ^ c[63];
      bs = bb[63] ^ sub;
      anynan = is_nan(a) || is_nan(bb) || is_nan(c);
      r.vxsnan = is_snan(a) || is_snan(bb) || is_snan(c);
      r.vximz = !anynan && ((is_inf(a) && is_zero(c)) || (is_zero(a) && is_inf(c)));
      pinf = !anynan && !r.vximz && (is_inf(a) || is_inf(c));
      r.vxisi = pinf && is_inf(bb) && (ps != bs);
      r.nowrite = invalid_enable_bit && (r.vxsnan || r.vxisi || r.vximz);
      den = 1'b0;
      if (anynan)
      begin
         // NaNs pass through unnegated, quieted, sign untouched
         r.data = is_nan(a) ? a : (is_nan(bb) ? bb : c);
         r.data = r.data | `FMN_QUIET_MASK;
         if (sgl)
            r.data = r.data & `FMN_SGL_KEEP;
      end
      else if (r.vxisi || r.vximz)
         r.data = `FMN_DEF_QNAN;
      else if (pinf)
         r.data = {ps ^ neg, 11'h7FF, 52'h0};
      else if (is_inf(bb))
         r.data = {bs ^ neg, 11'h7FF, 52'h0};
      else
      begin
         ea = (a[62:52] == 11'h0) ? 11'd1 : a[62:52];
         eb = (bb[62:52] == 11'h0) ? 11'd1 : bb[62:52];
         ec = (c[62:52] == 11'h0) ? 11'd1 : c[62:52];
         ma = {|a[62:52], a[51:0]};
         mb = {|bb[62:52], bb[51:0]};
         mc = {|c[62:52], c[51:0]};
         pm = ma * mc;
         xb = int'(ea) + int'(ec) - `FMN_XB_OFS;
         yb = int'(eb) - `FMN_YB_OFS;
         x = {pm, 4'h0};
         y = {mb, 57'h0};
         big = (xb >= yb) ? x : y;
         sml = (xb >= yb) ? y : x;
         bse = (xb >= yb) ? xb : yb;
         d = (xb >= yb) ? xb - yb : yb - xb;
         // Far operand shifts out with its lost bits jammed into bit 0
         if (d >= 110)
            sh = {109'h0, |sml};
         else
         begin
            sh = sml >> d;
            sh[0] = sh[0] | (|(sml & ((110'd1 << d) - 110'd1)));
         end
         rs = (xb >= yb) ? ps : bs;
         if (ps == bs)
            n = {1'b0, big} + {1'b0, sh};
         else if (big >= sh)
            n = {1'b0, big} - {1'b0, sh};
         else
         begin
            n = {1'b0, sh} - {1'b0, big};
            rs = !rs;
         end
         if (n == 111'h0)
         begin
            rs = (ps == bs) ? ps : (rounding_mode_field == `FMN_RND_MINF);
            r.data = {rs ^ neg, 63'h0};
         end
         else
         begin
            lz = lzc(n);
            n = n << lz;
            e = bse + 110 - int'(lz);
            emin = sgl ? `FMN_EMIN_SGL : `FMN_EMIN_DBL;
            emax = sgl ? `FMN_EMAX_SGL : `FMN_EMAX_DBL;
            p = sgl ? `FMN_PREC_SGL : `FMN_PREC_DBL;
            tiny = e < emin;
            s = 111 - p + (tiny ? emin - e : 0);
            if (tiny)
               e = emin;
            if (s > 111)
            begin
               mfull = 111'h0;
               g = 1'b0;
               st = 1'b1;
            end
            else
            begin
               mfull = n >> s;
               g = n[s - 1];
               st = |(n & ((111'd1 << (s - 1)) - 111'd1));
            end
            m = mfull[53:0];
            case (rounding_mode_field)
               `FMN_RND_NEAR: inc = g && (st || m[0]);
               `FMN_RND_ZERO: inc = 1'b0;
               `FMN_RND_PINF: inc = !rs && (g || st);
               default: inc = rs && (g || st);
            endcase
            m = m + {53'h0, inc};
            if (m[p])
            begin
               m = m >> 1;
               e = e + 1;
            end
            r.xx = g || st;
            r.fi = r.xx;
            r.fr = inc;
            r.ux = tiny && r.xx;
            if (e > emax)
            begin
               r.overflow_flag = 1'b1;
               r.xx = 1'b1;
               r.fi = 1'b1;
               toinf = (rounding_mode_field == `FMN_RND_NEAR)
                  || (rounding_mode_field == `FMN_RND_PINF && !rs)
                  || (rounding_mode_field == `FMN_RND_MINF && rs);
               r.fr = toinf;
               m = (54'd1 << p) - 54'd1;
               e = emax;
            end
            else
               toinf = 1'b0;
            fm = 53'(m << (53 - p));
            den = (fm != 53'h0) && !fm[52];
            // Single results live in double format, so tiny singles renormalize
            if (toinf)
               r.data = {rs, 11'h7FF, 52'h0};
            else if (fm == 53'h0)
               r.data = {rs, 63'h0};
            else if (fm[52])
               r.data = {rs, 11'(e + `FMN_BIAS), fm[51:0]};
            else if (!sgl)
               r.data = {rs, 11'h0, fm[51:0]};
            else
            begin
               lz = lzc({fm, 58'h0});
               fm = fm << lz;
               r.data = {rs, 11'(e - int'(lz) + `FMN_BIAS), fm[51:0]};
            end
            r.data[63] = r.data[63] ^ neg;
         end
      end
      r.result_class_field = fp_class(r.data, den);
      return r;
   endfunction

   // Instruction decode
   always_comb
   begin
      op = OP_NONE;
      if (i_issue.instr[31:26] == `FMN_PRIM_DBL || i_issue.instr[31:26] == `FMN_PRIM_SGL)
      begin
         case (i_issue.instr[5:1])
            `FMN_XO_MUL: op = OP_MUL;
            `FMN_XO_NMADD: op = OP_NMADD;
            `FMN_XO_NMSUB: op = OP_NMSUB;
            default: op = OP_NONE;
         endcase
         if (i_issue.instr[31:26] == `FMN_PRIM_DBL)
         begin
            if (i_issue.instr[10:1] == `FMN_XO_NABS)
               op = OP_NABS;
            else if (i_issue.instr[10:1] == `FMN_XO_NEG)
               op = OP_NEG;
         end
      end
   end

   always_comb
   begin
      ar = fma_core(i_issue.opa, i_issue.opb, i_issue.opc,
         i_issue.instr[31:26] == `FMN_PRIM_SGL, op == OP_NMSUB, op == OP_MUL,
         op != OP_MUL, q.ctrl[1:0], q.ctrl[`FMN_CTRL_INV_EN]);
   end

   always_comb
   begin
      nx = q;
      nx.res.valid = 1'b0;
      nx.res.we = 1'b0;
      nx.res.illegal = 1'b0;
      nx.upd = '0;
      nx.cr.we = 1'b0;
      nx.rdata = 32'h0;
      if (i_reg_re)
      begin
         case (i_reg_addr)
            `FMN_ADDR_CTRL: nx.rdata = {26'h0, q.ctrl};
            `FMN_ADDR_STAT: nx.rdata = {28'h0, q.stat};
            `FMN_ADDR_MASK: nx.rdata = {28'h0, q.mask};
            default: nx.rdata = 32'h0;
         endcase
      end
      if (i_reg_we && i_reg_addr == `FMN_ADDR_CTRL)
         nx.ctrl = i_reg_wdata[5:0];
      if (i_reg_we && i_reg_addr == `FMN_ADDR_MASK)
         nx.mask = i_reg_wdata[3:0];
      if (i_reg_we && i_reg_addr == `FMN_ADDR_STAT)
         nx.stat = q.stat & ~i_reg_wdata[3:0];
      if (i_issue.valid)
      begin
         nx.res.valid = 1'b1;
         nx.res.dst = i_issue.instr[25:21];
         nx.res.illegal = (op == OP_NONE);
         case (op)
            OP_NABS:
            begin
               nx.res.we = 1'b1;
               nx.res.data = {1'b1, i_issue.opb[62:0]};
            end
            OP_NEG:
            begin
               nx.res.we = 1'b1;
               nx.res.data = {~i_issue.opb[63], i_issue.opb[62:0]};
            end
            OP_MUL, OP_NMADD, OP_NMSUB:
            begin
               // Enabled invalid leaves the target and class field untouched
               nx.res.we = !ar.nowrite;
               nx.res.data = ar.data;
               nx.upd.we = 1'b1;
               nx.upd.result_class_field_we = !ar.nowrite;
               nx.upd.result_class_field = ar.result_class_field;
               nx.upd.fr = ar.fr;
               nx.upd.fi = ar.fi;
               nx.upd.overflow_flag = ar.overflow_flag;
               nx.upd.ux = ar.ux;
               nx.upd.xx = ar.xx;
               nx.upd.vxsnan = ar.vxsnan;
               nx.upd.vxisi = ar.vxisi;
               nx.upd.vximz = ar.vximz;
               nx.upd.invalid_summary = ar.vxsnan || ar.vxisi || ar.vximz;
               nx.upd.exception_summary = nx.upd.invalid_summary || ar.overflow_flag
                  || ar.ux || ar.xx;
               nx.upd.enabled_exception_summary = (nx.upd.invalid_summary
                  && q.ctrl[`FMN_CTRL_INV_EN])
                  || (ar.overflow_flag && q.ctrl[`FMN_CTRL_OE])
                  || (ar.ux && q.ctrl[`FMN_CTRL_UE])
                  || (ar.xx && q.ctrl[`FMN_CTRL_XE]);
               // Set wins over a same-cycle write-one clear
               nx.stat[`FMN_EV_INV] = nx.stat[`FMN_EV_INV] | nx.upd.invalid_summary;
               nx.stat[`FMN_EV_OVF] = nx.stat[`FMN_EV_OVF] | ar.overflow_flag;
               nx.stat[`FMN_EV_UNF] = nx.stat[`FMN_EV_UNF] | ar.ux;
               nx.stat[`FMN_EV_INX] = nx.stat[`FMN_EV_INX] | ar.xx;
            end
            default:
               nx.res.we = 1'b0;
         endcase
         // Summaries are sticky in the status register, so merge the core's copy
         if (i_issue.instr[0] && op != OP_NONE)
         begin
            nx.cr.we = 1'b1;
            nx.cr.val = i_fp_sum | {nx.upd.exception_summary, nx.upd.enabled_exception_summary,
               nx.upd.invalid_summary, nx.upd.overflow_flag};
         end
      end
      nx.irq = |(nx.stat & nx.mask);
   end

   always_ff @(posedge i_ref_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         q <= '0;
         q.ctrl <= `FMN_CTRL_RST;
      end
      else
         q <= nx;
   end

   assign o_reg_rdata = q.rdata;
   assign o_res = q.res;
   assign o_upd = q.upd;
   assign o_cond_field_one = q.cr;
   assign o_irq = q.irq;
endmodule
`default_nettype wire

// ===== fmn_core_model.sv
// Issue side of the core: hands one instruction per send call to the unit.
// Assumes one bench process calls send, then idle or another send.
`timescale 1ns/1ns
`default_nettype none
module fmn_core_model
   import fmn_pkg::*;
(
   input wire logic i_ref_clk,
   input wire fmn_res_t i_res,
   output fmn_issue_t o_issue,
   output logic [3:0] o_fp_sum
);
   int n_sent = 0;
   int n_done = 0;
   initial o_issue = '0;
   initial o_fp_sum = 4'h0;
   task automatic send(input logic [31:0] ins, input logic [63:0] a, b, c);
      @(posedge i_ref_clk);
      o_issue <= '{1'b1, ins, a, b, c};
      o_fp_sum <= 4'($urandom);
      n_sent++;
   endtask
   // Idle operands are scrambled so a stale value is never mistaken for live data
   task automatic idle();
      @(posedge i_ref_clk);
      o_issue <= {1'b0, ~o_issue[$bits(fmn_issue_t)-2:0]};
   endtask
   // Each result pulse counts once, so a doubled pulse shows at the end
   always @(posedge i_ref_clk)
      if (i_res.valid === 1'b1)
         n_done <= n_done + 1;
endmodule
`default_nettype wire

// ===== fmn_unit_chk.sv
// Port checker of the multiply and negate unit.
// Assumes it is bound into the unit and sees only its ports.
`timescale 1ns/1ns
`default_nettype none
`include "fmn_consts.svh"
module fmn_unit_chk
   import fmn_pkg::*;
(
   input wire logic i_ref_clk,
   input wire logic i_sys_rst,
   input wire fmn_issue_t i_issue,
   input wire logic [3:0] i_fp_sum,
   input wire fmn_res_t o_res,
   input wire fmn_upd_t o_upd,
   input wire fmn_cr_t o_cond_field_one
);
   wire [5:0] prim = i_issue.instr[31:26];
   wire [9:0] xo = i_issue.instr[10:1];
   wire vld = i_issue.valid;
   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (i_sys_rst);
   sequence s_nabs;
      vld && prim == `FMN_PRIM_DBL && xo == `FMN_XO_NABS;
   endsequence
   sequence s_neg;
      vld && prim == `FMN_PRIM_DBL && xo == `FMN_XO_NEG;
   endsequence
   sequence s_fused;
      vld && (prim == `FMN_PRIM_DBL || prim == `FMN_PRIM_SGL) && (xo[4:0] == `FMN_XO_MUL
         || xo[4:0] == `FMN_XO_NMADD || xo[4:0] == `FMN_XO_NMSUB);
   endsequence
   sequence s_answer;
      o_res.valid && !o_res.illegal;
   endsequence
   ans_latency_a: assert property (vld |=> o_res.valid)
      else $error("result pulse missing after issue");
   no_extra_a: assert property (!vld |=> !o_res.valid)
      else $error("result pulse without issue");
   dst_field_a: assert property (vld |=> o_res.dst == $past(i_issue.instr[25:21]))
      else $error("destination field wrong");
   nabs_sign_a: assert property (s_nabs |=> o_res.we && o_res.data ==
      {1'b1, $past(i_issue.opb[62:0])})
      else $error("negative absolute result wrong");
   neg_sign_a: assert property (s_neg |=> o_res.we && o_res.data ==
      {~$past(i_issue.opb[63]), $past(i_issue.opb[62:0])})
      else $error("negate result wrong");
   sign_status_a: assert property ((s_nabs or s_neg) |=> !o_upd.we)
      else $error("sign operation touched status");
   fused_status_a: assert property (s_fused |=> o_upd.we)
      else $error("arithmetic operation gave no status update");
   cr_record_a: assert property (s_answer |->
      o_cond_field_one.we == $past(i_issue.instr[0]))
      else $error("condition field write does not follow record bit");
   cr_value_a: assert property (o_cond_field_one.we |->
      (o_cond_field_one.val | $past(i_fp_sum)) == o_cond_field_one.val)
      else $error("condition field lost a summary bit");
   illegal_quiet_a: assert property (o_res.illegal |->
      !o_res.we && !o_upd.we && !o_cond_field_one.we)
      else $error("undecoded opcode had side effects");
   class_gate_a: assert property (o_upd.result_class_field_we |-> o_upd.we && o_res.we)
      else $error("class field written without a result");
endmodule
bind fmn_unit fmn_unit_chk i_chk (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
   .i_issue(i_issue), .i_fp_sum(i_fp_sum), .o_res(o_res), .o_upd(o_upd),
   .o_cond_field_one(o_cond_field_one));
`default_nettype wire

// ===== fmn_unit_bench.sv
// Self-checking bench of the multiply and negate unit.
// Assumes the core model and the bound checker are compiled before it.
`timescale 1ns/1ns
`default_nettype none
`include "fmn_consts.svh"
`define FMN_CHK(nm, e, s) begin n_checks++; if ((s) !== (e)) begin n_mismatch++; \
   $display("unexpected %s exp %h got %h", nm, e, s); end end
module fmn_unit_bench
   import fmn_pkg::*;
;
   localparam logic [63:0] k_one = 64'h3FF0_0000_0000_0000;
   localparam logic [63:0] k_two = 64'h4000_0000_0000_0000;
   localparam logic [63:0] k_three = 64'h4008_0000_0000_0000;
   localparam logic [9:0] x_mul = {5'h00, `FMN_XO_MUL};
   localparam logic [9:0] x_nmadd = {5'h00, `FMN_XO_NMADD};
   localparam logic [9:0] x_nmsub = {5'h00, `FMN_XO_NMSUB};
   logic i_ref_clk = 1'b0;
   logic i_sys_rst = 1'b1;
   fmn_issue_t iss;
   logic [3:0] sum;
   logic [3:0] addr = 4'h0;
   logic [31:0] wdata = 32'h0;
   logic we = 1'b0;
   logic re = 1'b0;
   logic re_d = 1'b0;
   logic bb = 1'b0;
   logic [31:0] rdata;
   logic [31:0] rx;
   logic [63:0] r;
   logic [72:0] n;
   logic [4:0] dst = 5'h00;
   fmn_res_t res;
   fmn_upd_t upd;
   fmn_cr_t cond;
   logic irq;
   logic [72:0] nq[$];
   logic [31:0] rq[$];
   logic [3:0] cq[$];
   logic [3:0] cx = 4'h0;
   logic [3:0] c4;
   logic [3:0] sum_d = 4'h0;
   int n_mismatch = 0;
   int n_checks = 0;
   always #5 i_ref_clk = ~i_ref_clk;
   fmn_core_model i_core (.i_ref_clk(i_ref_clk), .i_res(res), .o_issue(iss), .o_fp_sum(sum));
   fmn_unit i_dut (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_issue(iss),
      .i_fp_sum(sum), .i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_we(we),
      .i_reg_re(re), .o_reg_rdata(rdata), .o_res(res), .o_upd(upd),
      .o_cond_field_one(cond), .o_irq(irq));
   // Note layout: write, status, class write, cond write, class, data
   function automatic logic [72:0] nt(input logic [3:0] f, input logic [4:0] fp,
      input logic [63:0] d);
      return {f, fp, d};
   endfunction
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge i_ref_clk);
      addr <= a;
      wdata <= d;
      we <= 1'b1;
      @(posedge i_ref_clk);
      we <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      @(posedge i_ref_clk);
      addr <= a;
      re <= 1'b1;
      rq.push_back(e);
      @(posedge i_ref_clk);
      re <= 1'b0;
   endtask
   task automatic op(input logic [5:0] pr, input logic [9:0] xo, input logic rec,
      input logic [63:0] a, b, c, input logic [72:0] e);
      dst = dst + 5'h01;
      nq.push_back(e);
      cq.push_back(cx);
      i_core.send({pr, dst, 10'h000, xo, rec}, a, b, c);
      if (!bb)
         i_core.idle();
   endtask
   task automatic irq_is(input logic e);
      repeat (3) @(posedge i_ref_clk);
      @(negedge i_ref_clk);
      `FMN_CHK("irq", e, irq)
   endtask
   task final_report();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   always @(posedge i_ref_clk)
      re_d <= re;
   // Summaries the core offered at the issue edge, for the condition field check
   always @(posedge i_ref_clk)
      sum_d <= sum;
   always @(negedge i_ref_clk)
   begin
      if (re_d)
      begin
         rx = rq.pop_front();
         `FMN_CHK("rdata", rx, rdata)
      end
      if (res.valid === 1'b1)
      begin
         n = nq.pop_front();
         `FMN_CHK("we", n[72], res.we)
         `FMN_CHK("status_we", n[71], upd.we)
         `FMN_CHK("class_we", n[70], upd.result_class_field_we)
         `FMN_CHK("cond_we", n[69], cond.we)
         c4 = cq.pop_front();
         if (n[69])
            `FMN_CHK("cond", sum_d | c4, cond.val)
         if (n[70])
            `FMN_CHK("class", n[68:64], upd.result_class_field)
         if (n[72])
            `FMN_CHK("data", n[63:0], res.data)
      end
   end
   // A full run takes just over a hundred cycles, so this only trips on a hang
   initial
   begin
      #50000;
      n_mismatch++;
      final_report();
   end
   initial
   begin
      r = 64'($urandom(32'h5EFE));
      repeat (20) @(posedge i_ref_clk);
      i_sys_rst <= 1'b0;
      rd(`FMN_ADDR_CTRL, 32'h0);
      rd(`FMN_ADDR_STAT, 32'h0);
      rd(`FMN_ADDR_MASK, 32'h0);
      wr(`FMN_ADDR_CTRL, 32'hFFFF_FFFF);
      rd(`FMN_ADDR_CTRL, 32'h0000_003F);
      wr(4'hC, 32'hFFFF_FFFF);
      rd(4'hC, 32'h0);
      wr(`FMN_ADDR_CTRL, 32'h0);
      $display("test registers done");
      op(`FMN_PRIM_DBL, x_mul, 1'b1, k_two, k_one, k_three,
         nt(4'hF, `FMN_CLS_PNORM, 64'h4018_0000_0000_0000));
      op(`FMN_PRIM_SGL, x_mul, 1'b0, 64'h3FF8_0000_0000_0000, k_one, 64'h3FF8_0000_0000_0000,
         nt(4'hE, `FMN_CLS_PNORM, 64'h4002_0000_0000_0000));
      op(`FMN_PRIM_SGL, x_mul, 1'b0, 64'h3FF0_0000_1000_0000, k_two, k_one,
         nt(4'hE, `FMN_CLS_PNORM, k_one));
      op(`FMN_PRIM_DBL, x_mul, 1'b0, 64'h1, k_two, 64'h4330_0000_0000_0000,
         nt(4'hE, `FMN_CLS_PNORM, 64'h0010_0000_0000_0000));
      op(`FMN_PRIM_DBL, x_nmadd, 1'b1, k_two, k_one, k_three,
         nt(4'hF, `FMN_CLS_NNORM, 64'hC01C_0000_0000_0000));
      op(`FMN_PRIM_SGL, x_nmadd, 1'b0, k_two, k_one, k_three,
         nt(4'hE, `FMN_CLS_NNORM, 64'hC01C_0000_0000_0000));
      op(`FMN_PRIM_DBL, x_nmsub, 1'b0, k_two, k_one, k_three,
         nt(4'hE, `FMN_CLS_NNORM, 64'hC014_0000_0000_0000));
      op(`FMN_PRIM_SGL, x_nmsub, 1'b1, k_two, k_one, k_three,
         nt(4'hF, `FMN_CLS_NNORM, 64'hC014_0000_0000_0000));
      $display("test arithmetic done");
      wr(`FMN_ADDR_CTRL, {30'h0, `FMN_RND_PINF});
      op(`FMN_PRIM_DBL, x_nmadd, 1'b0, 64'h3FF0_0000_0000_0001, 64'h0, 64'h3FF0_0000_0000_0001,
         nt(4'hE, `FMN_CLS_NNORM, 64'hBFF0_0000_0000_0003));
      wr(`FMN_ADDR_CTRL, {30'h0, `FMN_RND_MINF});
      op(`FMN_PRIM_DBL, x_nmadd, 1'b0, 64'h3FF0_0000_0000_0001, 64'h0, 64'h3FF0_0000_0000_0001,
         nt(4'hE, `FMN_CLS_NNORM, 64'hBFF0_0000_0000_0002));
      wr(`FMN_ADDR_CTRL, 32'h0);
      rd(`FMN_ADDR_STAT, 32'h0000_0008);
      wr(`FMN_ADDR_STAT, 32'h0000_000F);
      $display("test rounding done");
      op(`FMN_PRIM_DBL, x_nmadd, 1'b0, 64'hFFF8_0000_0000_0001, 64'h0, k_one,
         nt(4'hE, `FMN_CLS_QNAN, 64'hFFF8_0000_0000_0001));
      cx = 4'hA;
      op(`FMN_PRIM_DBL, x_nmsub, 1'b1, 64'h7FF0_0000_0000_0000, 64'h0, 64'h0,
         nt(4'hF, `FMN_CLS_QNAN, `FMN_DEF_QNAN));
      cx = 4'h0;
      op(`FMN_PRIM_DBL, x_nmadd, 1'b0, 64'hFFF0_0000_0000_0001, 64'h0, k_one,
         nt(4'hE, `FMN_CLS_QNAN, 64'hFFF8_0000_0000_0001));
      irq_is(1'b0);
      wr(`FMN_ADDR_MASK, 32'h0000_0001);
      irq_is(1'b1);
      rd(`FMN_ADDR_STAT, 32'h0000_0001);
      wr(`FMN_ADDR_STAT, 32'h0000_0001);
      irq_is(1'b0);
      rd(`FMN_ADDR_STAT, 32'h0);
      wr(`FMN_ADDR_CTRL, 32'h0000_0004);
      cx = 4'hE;
      op(`FMN_PRIM_DBL, x_nmadd, 1'b1, 64'hFFF0_0000_0000_0001, 64'h0, k_one,
         nt(4'h5, 5'h00, 64'h0));
      cx = 4'h0;
      wr(`FMN_ADDR_CTRL, 32'h0);
      $display("test nan and interrupt done");
      bb = 1'b1;
      repeat (4)
      begin
         r = {$urandom, $urandom};
         op(`FMN_PRIM_DBL, `FMN_XO_NABS, 1'b1, k_one, r, k_one,
            nt(4'h9, 5'h00, {1'b1, r[62:0]}));
         op(`FMN_PRIM_DBL, `FMN_XO_NEG, 1'b0, k_one, r, k_one,
            nt(4'h8, 5'h00, {~r[63], r[62:0]}));
      end
      op(`FMN_PRIM_DBL, `FMN_XO_NEG, 1'b0, k_one, 64'h7FF8_0000_0000_0001, k_one,
         nt(4'h8, 5'h00, 64'hFFF8_0000_0000_0001));
      op(6'h01, x_mul, 1'b1, k_one, k_one, k_one, nt(4'h0, 5'h00, 64'h0));
      bb = 1'b0;
      i_core.idle();
      $display("test sign and decode done");
      repeat (4) @(posedge i_ref_clk);
      `FMN_CHK("pending", 0, nq.size())
      `FMN_CHK("results", i_core.n_sent, i_core.n_done)
      final_report();
   end
endmodule
`default_nettype wire
